// [i2cw_params.svh]
// Offsets, field positions, reset values and timing counts for the I2C start/stop control block.
// Assumes a 32-bit AXI4-Lite register window with one aligned word per register.
`ifndef I2CW_PARAMS_SVH
`define I2CW_PARAMS_SVH

// Register byte offsets.
`define I2CW_OFS_CONTROL 8'h00
`define I2CW_OFS_STATUS 8'h04
`define I2CW_OFS_FLAG 8'h08
`define I2CW_OFS_CLKSEL 8'h0c
`define I2CW_OFS_FUNCEXT 8'h10
`define I2CW_OFS_PRESCALE 8'h14
`define I2CW_OFS_OWNADDR 8'h18
`define I2CW_OFS_SHIFT 8'h1c

// Control register fields.
`define I2CW_CTL_ENABLE 7
`define I2CW_CTL_LREL 6
`define I2CW_CTL_SPIE 4
`define I2CW_CTL_STT 1
`define I2CW_CTL_SPT 0

// Status register fields.
`define I2CW_STS_MASTER 7
`define I2CW_STS_EXC 5
`define I2CW_STS_MATCH 4
`define I2CW_STS_RESV 3
`define I2CW_STS_STD 1
`define I2CW_STS_SPD 0

// Flag register fields.
`define I2CW_FLG_REJECT 7
`define I2CW_FLG_BUSY 6
`define I2CW_FLG_STCEN 1
`define I2CW_FLG_RSVDIS 0

// Prescaler register fields.
`define I2CW_PRE_ON 4

// Reset values.
`define I2CW_RST_BYTE 8'h00

// Decision delay in operating clocks, and line hold time of generated conditions.
`define I2CW_DECIDE_TICKS 4'h5
`define I2CW_HOLD_TICKS 4'h4

// AXI responses.
`define I2CW_RESP_OKAY 2'b00
`define I2CW_RESP_SLVERR 2'b10

`endif

// [i2cw_pkg.sv]
// Types shared by the I2C start/stop control block.
// Assumes the constants header is included by the design files.
package i2cw_pkg;

  // Line driver sequencer states.
  typedef enum logic [2:0] {
    I2CW_IDLE,
    I2CW_START,
    I2CW_WAIT,
    I2CW_STOP_LOW,
    I2CW_STOP_REL
  } i2cw_drv_t;

  typedef logic [7:0] i2cw_byte_t;

endpackage

// [i2cw_sync.sv]
// Three-stage input synchroniser with an agreement filter.
// Assumes an asynchronous pin input; output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module i2cw_sync (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Chain resets high so an idle bus reads released.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Only stages two and three are compared, so a metastable first stage is never seen.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      level_out <= 1'b1;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end
endmodule
`default_nettype wire

// [i2cw_top.sv]
// Start/stop control of an I2C bus interface: wakeup filter, reservation, bus state.
// Assumes an AXI4-Lite master on the register side and open-drain bus lines outside.
`timescale 1ns/1ps
`include "i2cw_params.svh"
`default_nettype none
module i2cw_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic arb_lost,
  input wire logic scl_line_i,
  output logic scl_line_o,
  output logic scl_line_oe,
  input wire logic sda_line_i,
  output logic sda_line_o,
  output logic sda_line_oe,
  output logic bus_irq,
  output logic xfer_go,
  output i2cw_pkg::i2cw_byte_t xfer_data
);
  import i2cw_pkg::*;

  i2cw_byte_t control_reg, flag_cfg_reg, clock_select_reg, function_ext_reg;
  i2cw_byte_t prescaler_select_reg, own_address_reg, addr_shift_reg;
  logic aw_got_reg, w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic wr_fire;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic start_det, stop_det, scl_rise, scl_fall;
  logic master_status_reg, slave_active_reg, ext_code_flag_reg, standby_reg;
  logic start_detected_reg, stop_detected_reg, bus_busy_reg, reserve_reg;
  logic start_rejected_reg, enable_d_reg, stt_d_reg, spt_d_reg;
  logic stt_rise, spt_rise, enable_rise, shift_write, decide_now, fire_start;
  logic [3:0] bit_cnt_reg;
  logic [3:0] decide_cnt_reg;
  logic deciding_reg;
  logic [2:0] pre_cnt_reg;
  logic [2:0] pre_div;
  logic op_tick;
  logic [3:0] hold_cnt_reg;
  i2cw_drv_t drv_reg;

  // Both bus lines pass the same three-stage filter.
  i2cw_sync u_scl_sync (
    .clock(clock),
    .resetn(resetn),
    .pin_in(scl_line_i),
    .level_out(scl_s)
  );
  i2cw_sync u_sda_sync (
    .clock(clock),
    .resetn(resetn),
    .pin_in(sda_line_i),
    .level_out(sda_s)
  );

  // AXI write channel: address and data are taken in either order, answered together.
  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `I2CW_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg[7:5] == 3'h0 && aw_addr_reg[1:0] == 2'h0) ?
                       `I2CW_RESP_OKAY : `I2CW_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // A register write lands only when byte lane zero is enabled.
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_fire && w_lane_reg && (aw_addr_reg == ofs);
  endfunction

  // Software registers. Clock settings are expected to stay fixed while enabled.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control_reg <= `I2CW_RST_BYTE;
      flag_cfg_reg <= `I2CW_RST_BYTE;
      clock_select_reg <= `I2CW_RST_BYTE;
      function_ext_reg <= `I2CW_RST_BYTE;
      prescaler_select_reg <= `I2CW_RST_BYTE;
      own_address_reg <= `I2CW_RST_BYTE;
    end else begin
      if (wr_hit(`I2CW_OFS_CONTROL)) begin
        control_reg <= w_data_reg;
      end else begin
        control_reg[`I2CW_CTL_LREL] <= 1'b0; // Release is a one-shot command.
      end
      if (wr_hit(`I2CW_OFS_FLAG)) begin
        flag_cfg_reg <= w_data_reg & 8'h03;
      end
      if (wr_hit(`I2CW_OFS_CLKSEL)) begin
        clock_select_reg <= w_data_reg;
      end
      if (wr_hit(`I2CW_OFS_FUNCEXT)) begin
        function_ext_reg <= w_data_reg & 8'h01;
      end
      if (wr_hit(`I2CW_OFS_PRESCALE)) begin
        prescaler_select_reg <= w_data_reg & 8'h13;
      end
      if (wr_hit(`I2CW_OFS_OWNADDR)) begin
        own_address_reg <= w_data_reg;
      end
    end
  end

  // Data written to the shift register is handed to the byte engine.
  // Written out in full: a function call here would only re-evaluate on its constant argument.
  assign shift_write = wr_fire && w_lane_reg && (aw_addr_reg == `I2CW_OFS_SHIFT);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      xfer_data <= 8'h00;
    end else if (shift_write) begin
      xfer_data <= w_data_reg;
    end
  end

  // AXI read channel, one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `I2CW_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `I2CW_RESP_OKAY;
      unique case (s_axi_araddr)
        `I2CW_OFS_CONTROL: s_axi_rdata <= {24'h0, control_reg};
        `I2CW_OFS_STATUS: s_axi_rdata <= {24'h0, master_status_reg, 1'b0, ext_code_flag_reg,
                                          slave_active_reg, reserve_reg, 1'b0,
                                          start_detected_reg, stop_detected_reg};
        `I2CW_OFS_FLAG: s_axi_rdata <= {24'h0, start_rejected_reg, bus_busy_reg, 4'h0,
                                        flag_cfg_reg[1:0]};
        `I2CW_OFS_CLKSEL: s_axi_rdata <= {24'h0, clock_select_reg};
        `I2CW_OFS_FUNCEXT: s_axi_rdata <= {24'h0, function_ext_reg};
        `I2CW_OFS_PRESCALE: s_axi_rdata <= {24'h0, prescaler_select_reg};
        `I2CW_OFS_OWNADDR: s_axi_rdata <= {24'h0, own_address_reg};
        `I2CW_OFS_SHIFT: s_axi_rdata <= {24'h0, addr_shift_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `I2CW_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Operating clock enable: undivided, or divided by two to five when the prescaler is on.
  assign pre_div = prescaler_select_reg[`I2CW_PRE_ON] ?
                   (3'h1 + {1'b0, prescaler_select_reg[1:0]}) : 3'h0;
  assign op_tick = (pre_cnt_reg == 3'h0);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_reg <= 3'h0;
    end else if (op_tick) begin
      pre_cnt_reg <= pre_div;
    end else begin
      pre_cnt_reg <= pre_cnt_reg - 3'h1;
    end
  end

  // Bus condition detection from the filtered lines.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign start_det = control_reg[`I2CW_CTL_ENABLE] && scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = control_reg[`I2CW_CTL_ENABLE] && scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;

  // Request bits act on their rising edge, so a second set needs a clear first.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      enable_d_reg <= 1'b0;
      stt_d_reg <= 1'b0;
      spt_d_reg <= 1'b0;
    end else begin
      enable_d_reg <= control_reg[`I2CW_CTL_ENABLE];
      stt_d_reg <= control_reg[`I2CW_CTL_STT];
      spt_d_reg <= control_reg[`I2CW_CTL_SPT];
    end
  end

  assign enable_rise = control_reg[`I2CW_CTL_ENABLE] && !enable_d_reg;
  assign stt_rise = control_reg[`I2CW_CTL_STT] && !stt_d_reg;
  assign spt_rise = control_reg[`I2CW_CTL_SPT] && !spt_d_reg;

  // Address receiver: eight bits sampled on clock rising edges after a start.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_reg <= 4'h0;
      addr_shift_reg <= 8'h00;
    end else if (start_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (standby_reg && scl_rise && bit_cnt_reg != 4'h8) begin
      addr_shift_reg <= {addr_shift_reg[6:0], sda_s};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Start request decision counted in operating clocks; a rejection shows by its end.
  assign decide_now = deciding_reg && op_tick && decide_cnt_reg == 4'h1;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      deciding_reg <= 1'b0;
      decide_cnt_reg <= 4'h0;
    end else if (stt_rise) begin
      deciding_reg <= 1'b1;
      decide_cnt_reg <= `I2CW_DECIDE_TICKS;
    end else if (deciding_reg && op_tick) begin
      decide_cnt_reg <= decide_cnt_reg - 4'h1;
      deciding_reg <= (decide_cnt_reg != 4'h1);
    end
  end

  // A start goes out on a decision with a free bus or while master, or when a stop ends a reservation.
  assign fire_start = (decide_now && (!bus_busy_reg || master_status_reg))
                      || (stop_det && reserve_reg);

  // Bus state and role tracking.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_busy_reg <= 1'b0;
      master_status_reg <= 1'b0;
      slave_active_reg <= 1'b0;
      ext_code_flag_reg <= 1'b0;
      standby_reg <= 1'b0;
      start_detected_reg <= 1'b0;
      stop_detected_reg <= 1'b0;
      reserve_reg <= 1'b0;
    end else if (!control_reg[`I2CW_CTL_ENABLE]) begin
      bus_busy_reg <= 1'b0;
      master_status_reg <= 1'b0;
      slave_active_reg <= 1'b0;
      ext_code_flag_reg <= 1'b0;
      standby_reg <= 1'b0;
      start_detected_reg <= 1'b0;
      stop_detected_reg <= 1'b0;
      reserve_reg <= 1'b0;
    end else if (enable_rise) begin
      bus_busy_reg <= !flag_cfg_reg[`I2CW_FLG_STCEN];
    end else begin
      if (start_det) begin
        bus_busy_reg <= 1'b1;
        start_detected_reg <= 1'b1;
        stop_detected_reg <= 1'b0;
        ext_code_flag_reg <= 1'b0;
        slave_active_reg <= 1'b0;
        standby_reg <= 1'b1;
      end
      if (standby_reg && scl_fall && bit_cnt_reg == 4'h8) begin
        standby_reg <= 1'b0;
        if (addr_shift_reg[7:4] == 4'h0 || addr_shift_reg[7:4] == 4'hf) begin
          ext_code_flag_reg <= 1'b1;
        end
        if (addr_shift_reg[7:1] == own_address_reg[7:1]) begin
          slave_active_reg <= 1'b1;
        end
      end
      if (control_reg[`I2CW_CTL_LREL] || arb_lost) begin
        slave_active_reg <= 1'b0;
        ext_code_flag_reg <= 1'b0;
        standby_reg <= 1'b0;
      end
      if (arb_lost) begin
        master_status_reg <= 1'b0;
      end
      if (decide_now && bus_busy_reg && !master_status_reg && !slave_active_reg &&
          !flag_cfg_reg[`I2CW_FLG_RSVDIS] && start_detected_reg) begin
        reserve_reg <= 1'b1;
      end
      if (stop_det) begin
        bus_busy_reg <= 1'b0;
        start_detected_reg <= 1'b0;
        stop_detected_reg <= 1'b1;
        slave_active_reg <= 1'b0;
        master_status_reg <= 1'b0;
        standby_reg <= 1'b0;
        reserve_reg <= 1'b0;
      end
      if (fire_start) begin
        master_status_reg <= 1'b1;
        bus_busy_reg <= 1'b1;
      end
    end
  end

  // Rejection flag: set wins over the software clear of the same cycle.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      start_rejected_reg <= 1'b0;
    end else if (decide_now && bus_busy_reg && !master_status_reg && !slave_active_reg &&
                 flag_cfg_reg[`I2CW_FLG_RSVDIS]) begin
      start_rejected_reg <= 1'b1;
    end else if (wr_hit(`I2CW_OFS_FLAG) && !w_data_reg[`I2CW_FLG_REJECT]) begin
      start_rejected_reg <= 1'b0;
    end
  end

  // Interrupt: stop by its enable alone, address only on a match, an extension code or while master.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_irq <= 1'b0;
    end else begin
      bus_irq <= (stop_det && control_reg[`I2CW_CTL_SPIE])
                 || (standby_reg && scl_fall && bit_cnt_reg == 4'h8 && !arb_lost &&
                     (addr_shift_reg[7:4] == 4'h0 || addr_shift_reg[7:4] == 4'hf ||
                      addr_shift_reg[7:1] == own_address_reg[7:1] ||
                      master_status_reg));
    end
  end

  // Line sequencer: generated start ends in a wait with the clock held low.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      drv_reg <= I2CW_IDLE;
      hold_cnt_reg <= 4'h0;
      xfer_go <= 1'b0;
    end else begin
      xfer_go <= 1'b0;
      if (hold_cnt_reg != 4'h0 && op_tick) begin
        hold_cnt_reg <= hold_cnt_reg - 4'h1;
      end
      if (!control_reg[`I2CW_CTL_ENABLE]) begin
        drv_reg <= I2CW_IDLE;
        hold_cnt_reg <= 4'h0;
      end else begin
        unique case (drv_reg)
          I2CW_IDLE: begin
            if (fire_start) begin
              drv_reg <= I2CW_START;
              hold_cnt_reg <= `I2CW_HOLD_TICKS;
            end else if (spt_rise) begin
              drv_reg <= I2CW_STOP_LOW;
              hold_cnt_reg <= `I2CW_HOLD_TICKS;
            end
          end
          I2CW_START: begin
            if (hold_cnt_reg == 4'h0) begin
              drv_reg <= I2CW_WAIT;
            end
          end
          I2CW_WAIT: begin
            if (shift_write) begin
              drv_reg <= I2CW_IDLE;
              xfer_go <= 1'b1;
            end else if (spt_rise) begin
              drv_reg <= I2CW_STOP_LOW;
              hold_cnt_reg <= `I2CW_HOLD_TICKS;
            end
          end
          I2CW_STOP_LOW: begin
            if (hold_cnt_reg == 4'h0) begin
              drv_reg <= I2CW_STOP_REL;
              hold_cnt_reg <= `I2CW_HOLD_TICKS;
            end
          end
          I2CW_STOP_REL: begin
            if (hold_cnt_reg == 4'h0) begin
              drv_reg <= I2CW_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Open-drain outputs only ever pull low; the enable marks the pull.
  assign scl_line_o = 1'b0;
  assign sda_line_o = 1'b0;
  assign scl_line_oe = (drv_reg == I2CW_WAIT);
  assign sda_line_oe = (drv_reg == I2CW_START) || (drv_reg == I2CW_WAIT) ||
                       (drv_reg == I2CW_STOP_LOW);
endmodule
`default_nettype wire

// [i2cw_asserts.sv]
// Port-level assertions for the I2C start/stop control block.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module i2cw_asserts (
  input wire logic clock,
  input wire logic resetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_line_oe,
  input wire logic sda_line_oe,
  input wire logic bus_irq,
  input wire logic xfer_go
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // A generated start holds data low alone before the clock line is pulled.
  sequence s_start_hold;
    (sda_line_oe && !scl_line_oe) [*4];
  endsequence
  // A stop from idle ends with data released instead of entering the wait.
  sequence s_enter_wait;
    ##[1:30] (scl_line_oe || !sda_line_oe);
  endsequence
  AST_START_SEQ: assert property ($rose(sda_line_oe) && !scl_line_oe |->
    s_start_hold ##0 s_enter_wait) else $error("start hold or wait entry wrong");
  AST_WAIT_BOTH: assert property (scl_line_oe |-> sda_line_oe)
    else $error("clock held without data held");
  AST_GO_FROM_WAIT: assert property (xfer_go |-> $past(scl_line_oe) && !scl_line_oe
    && !sda_line_oe) else $error("transfer start not from wait");
  AST_WAIT_LEAVE: assert property ($fell(scl_line_oe) |-> xfer_go)
    else $error("wait left without data write");
  AST_SDA_FREE: assert property ($fell(sda_line_oe) |-> !scl_line_oe)
    else $error("data released while clock still held");
  AST_GO_PULSE: assert property (xfer_go |=> !xfer_go)
    else $error("transfer start longer than one cycle");
  AST_IRQ_PULSE: assert property (bus_irq |=> !bus_irq)
    else $error("interrupt longer than one cycle");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_R_HIGH: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper bits not zero");
endmodule
bind i2cw_top i2cw_asserts i2cw_asserts_i (.*);
`default_nettype wire

// [i2cw_bus_model.sv]
// Another master on the shared open-drain lines.
// Assumes pull-ups: a line is high unless some party pulls it low.
`timescale 1ns/1ps
`default_nettype none
module i2cw_bus_model (
  input wire logic clock,
  input wire logic dut_scl_oe,
  input wire logic dut_sda_oe,
  output logic scl_w,
  output logic sda_w
);
  logic pull_scl = 1'b0;
  logic pull_sda = 1'b0;
  // Wired-AND of both parties; a released line floats up.
  assign scl_w = !(dut_scl_oe || pull_scl);
  assign sda_w = !(dut_sda_oe || pull_sda);
  // One bus phase, long enough for the input filter to settle.
  task automatic ph();
    repeat (8) @(posedge clock);
  endtask
  task automatic start_c();
    @(posedge clock);
    pull_sda <= 1'b1;
    ph();
    pull_scl <= 1'b1;
    ph();
  endtask
  // Byte goes out MSB first; the ninth clock leaves data released.
  task automatic send(input logic [7:0] b);
    logic [8:0] v;
    v = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      pull_sda <= !v[i];
      ph();
      pull_scl <= 1'b0;
      ph();
      pull_scl <= 1'b1;
      ph();
    end
  endtask
  task automatic stop_c();
    pull_sda <= 1'b1;
    ph();
    pull_scl <= 1'b0;
    ph();
    pull_sda <= 1'b0;
    ph();
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Register-level tests of the start/stop control block against a bus model.
// Assumes the checker is bound to the top module by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import i2cw_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, arb_lost = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_v;
  logic [1:0] rd_r;
  logic scl_line_i, scl_line_o, scl_line_oe, sda_line_i, sda_line_o, sda_line_oe;
  logic bus_irq, xfer_go;
  i2cw_byte_t xfer_data;
  int failures = 0, cmp_count = 0, irq_cnt = 0, go_cnt = 0, n0;
  logic [7:0] adr [4] = '{8'h00, 8'hf0, 8'ha0, 8'h22};
  logic [31:0] eirq [4] = '{32'h1, 32'h1, 32'h1, 32'h0};
  logic [31:0] eext [4] = '{32'h20, 32'h20, 32'h0, 32'h0};
  always #2.5 clock = !clock;
  i2cw_top i2cw_top_i (.*);
  i2cw_bus_model m (.clock, .dut_scl_oe(scl_line_oe), .dut_sda_oe(sda_line_oe),
    .scl_w(scl_line_i), .sda_w(sda_line_i));
  // Pulse counters sample at the falling edge, where the outputs have settled.
  always @(negedge clock) begin
    if (bus_irq === 1'b1) irq_cnt++;
    if (xfer_go === 1'b1) go_cnt++;
  end
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Every wait is bounded; running out ends the run as a mismatch.
  task automatic tick(inout int n);
    n++;
    if (n > 900) begin
      chk("wait bound", 32'h0, 32'h1);
      stop_test();
    end
  endtask
  // Ready is sampled mid-cycle, so the handshake is the edge that follows.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic ta, tw, tb;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      tick(n);
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic ta, tr;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      rd_v = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      tick(n);
    end while (!tr);
  endtask
  task automatic wait_hold();
    int n;
    n = 0;
    while (scl_line_oe !== 1'b1) begin
      @(posedge clock);
      tick(n);
    end
  endtask
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(8'h08);
    chk("flag reset", 32'h0, rd_v);
    rd(8'h20);
    chk("unmapped resp", 32'h2, {30'h0, rd_r});
    $display("test reset done");
    // Free bus: the request turns straight into a start and a wait.
    wr(8'h08, 8'h02);
    wr(8'h00, 8'h90);
    rd(8'h08);
    chk("busy after enable", 32'h02, rd_v);
    wr(8'h00, 8'h92);
    repeat (40) @(posedge clock);
    rd(8'h04);
    chk("master", 32'h80, rd_v & 32'h88);
    wait_hold();
    wr(8'h1c, 8'ha5);
    chk("go count", 32'h1, go_cnt);
    chk("go data", 32'ha5, {24'h0, xfer_data});
    wr(8'h00, 8'h00);
    $display("test immediate start done");
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h80);
    rd(8'h08);
    chk("busy forced", 32'h40, rd_v);
    wr(8'h00, 8'h81);
    repeat (30) @(posedge clock);
    rd(8'h08);
    chk("busy after stop", 32'h0, rd_v);
    rd(8'h04);
    chk("stop seen", 32'h1, rd_v & 32'h1);
    chk("line out", 32'h0, {30'h0, scl_line_o, sda_line_o});
    wr(8'h00, 8'h00);
    $display("test busy forced done");
    // Address filter: only own address and extension codes raise an address interrupt; every stop interrupts too.
    wr(8'h18, 8'ha0);
    wr(8'h08, 8'h02);
    wr(8'h00, 8'h90);
    for (int i = 0; i < 4; i++) begin
      n0 = irq_cnt;
      m.start_c();
      m.send(adr[i]);
      chk("address irq", eirq[i], irq_cnt - n0);
      rd(8'h04);
      chk("ext flag", eext[i], rd_v & 32'h20);
      n0 = irq_cnt;
      m.stop_c();
      chk("stop irq", 32'h1, irq_cnt - n0);
    end
    $display("test address filter done");
    // Reservation while another master owns the bus.
    m.start_c();
    m.send(8'h22);
    @(posedge clock);
    arb_lost <= 1'b1;
    @(posedge clock);
    arb_lost <= 1'b0;
    wr(8'h00, 8'h92);
    repeat (40) @(posedge clock);
    rd(8'h04);
    chk("reserved", 32'h08, rd_v & 32'h88);
    chk("no early start", 32'h0, {31'h0, sda_line_oe});
    n0 = irq_cnt;
    m.stop_c();
    wait_hold();
    chk("reserved stop irq", 32'h1, irq_cnt - n0);
    wr(8'h1c, 8'h5a);
    chk("go count 2", 32'h2, go_cnt);
    chk("go data 2", 32'h5a, {24'h0, xfer_data});
    wr(8'h00, 8'h00);
    $display("test reservation done");
    // Reservation disabled: the request is refused and flagged.
    wr(8'h08, 8'h03);
    wr(8'h00, 8'h90);
    m.start_c();
    m.send(8'h22);
    wr(8'h00, 8'h92);
    repeat (30) @(posedge clock);
    rd(8'h08);
    chk("rejected", 32'h80, rd_v & 32'h80);
    chk("no start", 32'h0, {31'h0, sda_line_oe});
    m.stop_c();
    $display("test rejection done");
    stop_test();
  end
endmodule
`default_nettype wire
